// *** inc/rgs_params.svh ***
`ifndef RGS_PARAMS_SVH
`define RGS_PARAMS_SVH

// ============================================================
// register offsets (byte addresses, one word each)
`define RGS_OFF_W 8
`define RGS_OFF_DES 8'h00
`define RGS_OFF_FES 8'h04
`define RGS_OFF_FESS 8'h08
`define RGS_OFF_FBRE 8'h0C
`define RGS_OFF_SAFE_EN 8'h10
`define RGS_OFF_IRQ_STS 8'h14
`define RGS_OFF_IRQ_MASK 8'h18
`define RGS_OFF_SEQ_STS 8'h1C

// ============================================================
// field layout
`define RGS_MAX_SRC 16
`define RGS_IRQ_W 4
`define RGS_IRQ_DES 0
`define RGS_IRQ_FES 1
`define RGS_IRQ_SEQ_DONE 2
`define RGS_IRQ_CLR_DONE 3
`define RGS_SEQ_STS_PHASE_LO 0
`define RGS_SEQ_STS_PAD 2
`define RGS_SEQ_STS_CLR_BUSY 3
`define RGS_SEQ_STS_SAFE_REQ 4
`define RGS_SEQ_STS_EXIT_OK 5
`define RGS_FES_PLL_LOSS_BIT 3

// ============================================================
// reset values
`define RGS_RST_SRC 16'h0000
`define RGS_RST_IRQ 4'h0

// ============================================================
// timing: phase lengths in ns, cycle counts at 4 ns, rounded up
`define RGS_CLK_NS 4
`define RGS_PH1_NS 400
`define RGS_PH2_NS 200
`define RGS_PH3_NS 100
`define RGS_PH1_CYC ((`RGS_PH1_NS + `RGS_CLK_NS - 1) / `RGS_CLK_NS)
`define RGS_PH2_CYC ((`RGS_PH2_NS + `RGS_CLK_NS - 1) / `RGS_CLK_NS)
`define RGS_PH3_CYC ((`RGS_PH3_NS + `RGS_CLK_NS - 1) / `RGS_CLK_NS)
`define RGS_CNT_W 12

// ============================================================
// bus encodings
`define RGS_HTRANS_NONSEQ 2'h2
`define RGS_HTRANS_SEQ 2'h3

`endif

// *** inc/rgs_pkg.sv ***
`default_nettype none
`include "rgs_params.svh"

package rgs_pkg;

   // ============================================================
   // sequencer phases
   typedef enum logic [1:0] {
      RGS_SEQ_IDLE = 2'b00,
      RGS_SEQ_PH1 = 2'b01,
      RGS_SEQ_PH2 = 2'b10,
      RGS_SEQ_PH3 = 2'b11
   } rgs_seq_state_t;

   // ============================================================
   // outputs toward the mode controller and reset tree
   typedef struct packed {
      rgs_seq_state_t phase;
      logic reset_active;
      logic pad_drive;
   } rgs_seq_out_t;

   // ============================================================
   // clear synchroniser state
   typedef struct packed {
      logic [`RGS_MAX_SRC-1:0] stage1;
      logic [`RGS_MAX_SRC-1:0] stage2;
      logic [`RGS_MAX_SRC-1:0] apply;
   } rgs_clr_state_t;

   // ============================================================
   // main block state
   typedef struct packed {
      logic dp_act;
      logic dp_write;
      logic [`RGS_OFF_W-1:0] dp_addr;
      logic [31:0] rdata;
      logic [`RGS_MAX_SRC-1:0] des;
      logic [`RGS_MAX_SRC-1:0] fes;
      logic [`RGS_MAX_SRC-1:0] fess;
      logic [`RGS_MAX_SRC-1:0] fbre;
      logic [`RGS_MAX_SRC-1:0] safe_en;
      logic [`RGS_MAX_SRC-1:0] safe_prev;
      logic [`RGS_IRQ_W-1:0] irq_sts;
      logic [`RGS_IRQ_W-1:0] irq_mask;
      rgs_seq_state_t seq;
      logic [`RGS_CNT_W-1:0] cnt;
      logic pad;
      logic clr_busy_prev;
   } rgs_state_t;

endpackage

`default_nettype wire

// *** src/rgs_clear_sync.sv ***
`default_nettype none
`include "rgs_params.svh"

module rgs_clear_sync
   import rgs_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [`RGS_MAX_SRC-1:0] req,
   input wire logic abort,
   output logic [`RGS_MAX_SRC-1:0] apply,
   output logic busy
);

   rgs_clr_state_t st_reg;
   rgs_clr_state_t st_next;

   // ============================================================
   // three-stage clear path; a reset start flushes all three stages so
   // nothing half-done leaks into a later request
   always_comb begin
      st_next = st_reg;
      st_next.stage1 = abort ? `RGS_RST_SRC : req; // see RQ1
      st_next.stage2 = abort ? `RGS_RST_SRC : st_reg.stage1; // see RQ2
      st_next.apply = abort ? `RGS_RST_SRC : st_reg.stage2; // see RQ3
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign apply = st_reg.apply;
   assign busy = |{st_reg.stage1, st_reg.stage2, st_reg.apply};

endmodule

`default_nettype wire

// *** src/rgs_sequencer.sv ***
// The register offsets and the AHB-Lite register port were left to the implementer.
`default_nettype none
`include "rgs_params.svh"

// Contract
// RQ1 - flag clear takes two synchronised cycles
// RQ2 - reset during clear may abandon it
// RQ3 - abandoned clear never disturbs later clears
// RQ4 - software reads status back before software reset
// RQ5 - short starts phase three, long phase one
// RQ6 - per source short-select and pad-drive bits
// RQ7 - short plus pad-drive runs long sequence
// RQ8 - short plus pad-drive leaves pad undriven
// RQ9 - software never sets short with pad-drive
// RQ10 - safe exit blocked while cause active
// RQ11 - clearing safe cause flag may allow exit
// RQ12 - software removes safe cause before clearing
// RQ13 - low voltage with pll may flag pll loss
// RQ14 - flags set by source, cleared writing one
module rgs_sequencer
   import rgs_pkg::*;
#(
   parameter int N_DES = `RGS_MAX_SRC,
   parameter int N_FUN = `RGS_MAX_SRC,
   parameter int PH1_CYC = `RGS_PH1_CYC,
   parameter int PH2_CYC = `RGS_PH2_CYC,
   parameter int PH3_CYC = `RGS_PH3_CYC,
   parameter bit FIXED_SAFE_EXIT = 1'b0
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [`RGS_MAX_SRC-1:0] des_event,
   input wire logic [`RGS_MAX_SRC-1:0] fun_event,
   input wire logic [`RGS_MAX_SRC-1:0] safe_cond,
   input wire logic pll_in_use,
   input wire logic low_voltage_detector_upper,
   output rgs_seq_out_t seq_out,
   output logic ext_reset_out,
   output logic ext_reset_oe,
   output logic safe_request,
   output logic safe_exit_allow,
   output logic irq
);

   // ============================================================
   // elaboration checks
   initial begin
      if (N_DES < 1 || N_DES > `RGS_MAX_SRC) begin
         $error("N_DES out of range");
      end
      if (N_FUN < 1 || N_FUN > `RGS_MAX_SRC) begin
         $error("N_FUN out of range");
      end
      if (N_FUN <= `RGS_FES_PLL_LOSS_BIT) begin
         $error("N_FUN too small for pll loss flag");
      end
      if (PH1_CYC < 1 || PH1_CYC >= (1 << `RGS_CNT_W)) begin
         $error("PH1_CYC out of range");
      end
      if (PH2_CYC < 1 || PH2_CYC >= (1 << `RGS_CNT_W)) begin
         $error("PH2_CYC out of range");
      end
      if (PH3_CYC < 1 || PH3_CYC >= (1 << `RGS_CNT_W)) begin
         $error("PH3_CYC out of range");
      end
   end

   // ============================================================
   // helpers
   function automatic logic [`RGS_MAX_SRC-1:0] src_mask(input int n);
      logic [`RGS_MAX_SRC-1:0] m;
      m = '0;
      for (int i = 0; i < `RGS_MAX_SRC; i++) begin
         m[i] = (i < n);
      end
      return m;
   endfunction

   function automatic logic [`RGS_CNT_W-1:0] load_cnt(input int cyc);
      return `RGS_CNT_W'(cyc - 1);
   endfunction

   localparam logic [`RGS_MAX_SRC-1:0] DES_MASK = src_mask(N_DES);
   localparam logic [`RGS_MAX_SRC-1:0] FUN_MASK = src_mask(N_FUN);

   rgs_state_t st_reg;
   rgs_state_t st_next;

   logic [`RGS_MAX_SRC-1:0] clr_req_des;
   logic [`RGS_MAX_SRC-1:0] clr_req_fes;
   logic [`RGS_MAX_SRC-1:0] clr_apply_des;
   logic [`RGS_MAX_SRC-1:0] clr_apply_fes;
   logic clr_busy_des;
   logic clr_busy_fes;
   logic seq_start;
   logic addr_take;
   logic wr_now;
   logic [31:0] rd_val;
   logic [`RGS_MAX_SRC-1:0] des_in;
   logic [`RGS_MAX_SRC-1:0] fun_in;
   logic [`RGS_MAX_SRC-1:0] safe_rise;
   logic [`RGS_MAX_SRC-1:0] fun_set;
   logic [`RGS_MAX_SRC-1:0] short_ok;
   logic [`RGS_MAX_SRC-1:0] pad_req;
   logic go_long;
   logic go_pad;
   logic exit_blocked;

   // ============================================================
   // event qualification
   always_comb begin
      des_in = des_event & DES_MASK;
      fun_in = fun_event & FUN_MASK;
      safe_rise = safe_cond & ~st_reg.safe_prev & st_reg.safe_en & FUN_MASK;
      fun_set = fun_in | safe_rise;
      // brown-out while the pll runs also marks pll loss
      if (pll_in_use && low_voltage_detector_upper) begin
         fun_set[`RGS_FES_PLL_LOSS_BIT] = 1'b1; // see RQ13
      end
   end

   // ============================================================
   // sequence choice for functional sources
   always_comb begin
      // pad drive only counts when the short path is off
      short_ok = fun_in & st_reg.fess & ~st_reg.fbre; // see RQ6
      pad_req = fun_in & st_reg.fbre & ~st_reg.fess; // see RQ8
      // short plus pad falls back to the long sequence
      go_long = |(fun_in & ~short_ok) || (|des_in); // see RQ7
      go_pad = (|pad_req) || (|des_in);
      seq_start = (st_reg.seq == RGS_SEQ_IDLE) && ((|des_in) || (|fun_in));
   end

   // ============================================================
   // safe mode gating
   always_comb begin
      // exit follows the stored flags unless FIXED_SAFE_EXIT is set, so clearing
      // one early can release safe mode with the cause still present
      exit_blocked = |(st_reg.fes & st_reg.safe_en); // see RQ11
      if (FIXED_SAFE_EXIT) begin
         exit_blocked = exit_blocked || (|(safe_cond & st_reg.safe_en)); // see RQ10
      end
   end

   // ============================================================
   // bus slave, zero wait state
   always_comb begin
      addr_take = hsel && hready &&
                  (htrans == `RGS_HTRANS_NONSEQ ||
                   htrans == `RGS_HTRANS_SEQ);
      wr_now = st_reg.dp_act && st_reg.dp_write;
      clr_req_des = '0;
      clr_req_fes = '0;
      if (wr_now && st_reg.dp_addr == `RGS_OFF_DES) begin
         clr_req_des = hwdata[`RGS_MAX_SRC-1:0] & DES_MASK; // see RQ14
      end
      if (wr_now && st_reg.dp_addr == `RGS_OFF_FES) begin
         clr_req_fes = hwdata[`RGS_MAX_SRC-1:0] & FUN_MASK; // see RQ14
      end
   end

   always_comb begin
      rd_val = '0;
      case (haddr[`RGS_OFF_W-1:0])
         `RGS_OFF_DES: begin
            rd_val[`RGS_MAX_SRC-1:0] = st_reg.des;
         end
         `RGS_OFF_FES: begin
            rd_val[`RGS_MAX_SRC-1:0] = st_reg.fes;
         end
         `RGS_OFF_FESS: begin
            rd_val[`RGS_MAX_SRC-1:0] = st_reg.fess;
         end
         `RGS_OFF_FBRE: begin
            rd_val[`RGS_MAX_SRC-1:0] = st_reg.fbre;
         end
         `RGS_OFF_SAFE_EN: begin
            rd_val[`RGS_MAX_SRC-1:0] = st_reg.safe_en;
         end
         `RGS_OFF_IRQ_STS: begin
            rd_val[`RGS_IRQ_W-1:0] = st_reg.irq_sts;
         end
         `RGS_OFF_IRQ_MASK: begin
            rd_val[`RGS_IRQ_W-1:0] = st_reg.irq_mask;
         end
         `RGS_OFF_SEQ_STS: begin
            rd_val[`RGS_SEQ_STS_PHASE_LO +: 2] = st_reg.seq;
            rd_val[`RGS_SEQ_STS_PAD] = st_reg.pad;
            // lets software confirm a clear has landed
            rd_val[`RGS_SEQ_STS_CLR_BUSY] = clr_busy_des || clr_busy_fes; // see RQ4
            rd_val[`RGS_SEQ_STS_SAFE_REQ] = safe_request;
            rd_val[`RGS_SEQ_STS_EXIT_OK] = !exit_blocked;
         end
         default: begin
            rd_val = '0;
         end
      endcase
   end

   // ============================================================
   // clear synchronisers, flushed by any reset start
   rgs_clear_sync u_clr_des (
      .hclk(hclk),
      .hresetn(hresetn),
      .req(clr_req_des),
      .abort(seq_start), // see RQ2
      .apply(clr_apply_des),
      .busy(clr_busy_des)
   );

   rgs_clear_sync u_clr_fes (
      .hclk(hclk),
      .hresetn(hresetn),
      .req(clr_req_fes),
      .abort(seq_start), // see RQ2
      .apply(clr_apply_fes),
      .busy(clr_busy_fes)
   );

   // ============================================================
   // next state
   always_comb begin
      logic [`RGS_IRQ_W-1:0] irq_set;
      irq_set = '0;
      st_next = st_reg;

      st_next.dp_act = addr_take;
      st_next.dp_write = hwrite;
      st_next.dp_addr = haddr[`RGS_OFF_W-1:0];
      st_next.rdata = (addr_take && !hwrite) ? rd_val : '0;
      st_next.safe_prev = safe_cond;

      // flags: a new event beats a clear landing the same edge
      st_next.des = (st_reg.des & ~clr_apply_des) | des_in; // see RQ1
      st_next.fes = (st_reg.fes & ~clr_apply_fes) | fun_set; // see RQ1

      if (wr_now) begin
         case (st_reg.dp_addr)
            `RGS_OFF_FESS: begin
               st_next.fess = hwdata[`RGS_MAX_SRC-1:0] & FUN_MASK; // see RQ6
            end
            `RGS_OFF_FBRE: begin
               st_next.fbre = hwdata[`RGS_MAX_SRC-1:0] & FUN_MASK; // see RQ6
            end
            `RGS_OFF_SAFE_EN: begin
               st_next.safe_en = hwdata[`RGS_MAX_SRC-1:0] & FUN_MASK;
            end
            `RGS_OFF_IRQ_MASK: begin
               st_next.irq_mask = hwdata[`RGS_IRQ_W-1:0];
            end
            `RGS_OFF_IRQ_STS: begin
               st_next.irq_sts = st_reg.irq_sts & ~hwdata[`RGS_IRQ_W-1:0];
            end
            default: begin
               st_next.irq_mask = st_reg.irq_mask;
            end
         endcase
      end

      // sequencer
      case (st_reg.seq)
         RGS_SEQ_IDLE: begin
            if (seq_start) begin
               st_next.pad = go_pad; // see RQ8
               if (go_long) begin
                  st_next.seq = RGS_SEQ_PH1; // see RQ5
                  st_next.cnt = load_cnt(PH1_CYC);
               end else begin
                  st_next.seq = RGS_SEQ_PH3; // see RQ5
                  st_next.cnt = load_cnt(PH3_CYC);
               end
            end
         end
         RGS_SEQ_PH1: begin
            if (st_reg.cnt == '0) begin
               st_next.seq = RGS_SEQ_PH2;
               st_next.cnt = load_cnt(PH2_CYC);
            end else begin
               st_next.cnt = st_reg.cnt - `RGS_CNT_W'(1);
            end
         end
         RGS_SEQ_PH2: begin
            if (st_reg.cnt == '0) begin
               st_next.seq = RGS_SEQ_PH3;
               st_next.cnt = load_cnt(PH3_CYC);
            end else begin
               st_next.cnt = st_reg.cnt - `RGS_CNT_W'(1);
            end
         end
         RGS_SEQ_PH3: begin
            if (st_reg.cnt == '0) begin
               st_next.seq = RGS_SEQ_IDLE;
               st_next.pad = 1'b0;
               irq_set[`RGS_IRQ_SEQ_DONE] = 1'b1;
            end else begin
               st_next.cnt = st_reg.cnt - `RGS_CNT_W'(1);
            end
         end
         default: begin
            st_next.seq = RGS_SEQ_IDLE;
            st_next.pad = 1'b0;
         end
      endcase

      // interrupt events; set wins over a write-one clear
      st_next.clr_busy_prev = clr_busy_des || clr_busy_fes;
      irq_set[`RGS_IRQ_DES] = |des_in;
      irq_set[`RGS_IRQ_FES] = |fun_set;
      irq_set[`RGS_IRQ_CLR_DONE] = st_reg.clr_busy_prev &&
                                   !(clr_busy_des || clr_busy_fes);
      st_next.irq_sts = st_next.irq_sts | irq_set;
   end

   // ============================================================
   // state register; flags survive the sequencer's own resets
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= '{
            dp_act: 1'b0,
            dp_write: 1'b0,
            dp_addr: '0,
            rdata: '0,
            des: `RGS_RST_SRC,
            fes: `RGS_RST_SRC,
            fess: `RGS_RST_SRC,
            fbre: `RGS_RST_SRC,
            safe_en: `RGS_RST_SRC,
            safe_prev: `RGS_RST_SRC,
            irq_sts: `RGS_RST_IRQ,
            irq_mask: `RGS_RST_IRQ,
            seq: RGS_SEQ_IDLE,
            cnt: '0,
            pad: 1'b0,
            clr_busy_prev: 1'b0
         };
      end else begin
         st_reg <= st_next;
      end
   end

   // ============================================================
   // outputs
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = st_reg.rdata;
   assign seq_out = '{phase: st_reg.seq,
                      reset_active: (st_reg.seq != RGS_SEQ_IDLE),
                      pad_drive: st_reg.pad};
   // open drain: pull low only while driving
   assign ext_reset_out = 1'b0;
   assign ext_reset_oe = st_reg.pad;
   assign safe_request = |(safe_cond & st_reg.safe_en);
   assign safe_exit_allow = !exit_blocked; // see RQ10
   assign irq = |(st_reg.irq_sts & st_reg.irq_mask);

endmodule

`default_nettype wire

// *** tb/rgs_sequencer_sva.sv ***
`default_nettype none
`include "rgs_params.svh"

module rgs_sequencer_chk
   import rgs_pkg::*;
#(
   parameter int PH1_CYC = `RGS_PH1_CYC,
   parameter int PH3_CYC = `RGS_PH3_CYC
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [`RGS_MAX_SRC-1:0] des_event,
   input wire rgs_seq_out_t seq_out,
   input wire logic ext_reset_out,
   input wire logic ext_reset_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   // ============================================================
   // helper: length of the current phase run, current cycle included
   logic [11:0] cnt_reg;
   rgs_seq_state_t ph_reg;
   logic rd_reg;
   logic [11:0] run;
   rgs_seq_state_t ph;

   assign ph = seq_out.phase;
   assign run = (ph == ph_reg) ? cnt_reg + 12'h001 : 12'h001;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_reg <= 12'h000;
         ph_reg <= RGS_SEQ_IDLE;
         rd_reg <= 1'b0;
      end else begin
         cnt_reg <= run;
         ph_reg <= ph;
         rd_reg <= hsel && hready && htrans[1] && !hwrite;
      end
   end

   // ============================================================
   // properties
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_BUS_OK: assert property (hreadyout && !hresp)
      else $error("bus answer not ready or not okay");
   AST_STRUCT: assert property ((seq_out.reset_active == (ph != RGS_SEQ_IDLE))
      && (seq_out.pad_drive == ext_reset_oe))
      else $error("sequence outputs disagree");
   AST_PAD_LOW: assert property (!ext_reset_out)
      else $error("pad output level not low");
   AST_IDLE_OE: assert property (ph == RGS_SEQ_IDLE |-> !ext_reset_oe)
      else $error("pad driven outside a sequence");
   AST_DES_LONG: assert property (ph == RGS_SEQ_IDLE && |des_event
      |=> ph == RGS_SEQ_PH1 && ext_reset_oe)
      else $error("destructive event did not start long sequence");
   AST_PH1_HOLD: assert property (ph == RGS_SEQ_PH1 && run < PH1_CYC
      |=> ph == RGS_SEQ_PH1)
      else $error("phase one left early");
   AST_PH1_END: assert property (ph == RGS_SEQ_PH1 && run == PH1_CYC
      |=> ph == RGS_SEQ_PH2)
      else $error("phase one not followed by phase two");
   AST_PH2_NEXT: assert property (ph == RGS_SEQ_PH2
      |=> ph inside {RGS_SEQ_PH2, RGS_SEQ_PH3})
      else $error("phase two not followed by phase three");
   AST_PH3_HOLD: assert property (ph == RGS_SEQ_PH3 && run < PH3_CYC
      |=> ph == RGS_SEQ_PH3)
      else $error("phase three left early");
   AST_PH3_END: assert property (ph == RGS_SEQ_PH3 && run == PH3_CYC
      |=> ph == RGS_SEQ_IDLE)
      else $error("phase three too long");
   AST_OE_HOLD: assert property (seq_out.reset_active ##1
      seq_out.reset_active |-> $stable(ext_reset_oe))
      else $error("pad drive changed inside a sequence");
   AST_RD_ZERO: assert property (!rd_reg |-> hrdata == 32'h00000000)
      else $error("read data outside a read data phase");
endmodule

bind rgs_sequencer rgs_sequencer_chk #(.PH1_CYC(PH1_CYC), .PH3_CYC(PH3_CYC))
   u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .des_event(des_event), .seq_out(seq_out),
   .ext_reset_out(ext_reset_out), .ext_reset_oe(ext_reset_oe));

`default_nettype wire

// *** tb/rgs_src_model.sv ***
`default_nettype none

module rgs_src_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [15:0] des_req,
   input wire logic [15:0] fun_req,
   input wire logic ext_reset_out,
   input wire logic ext_reset_oe,
   output logic [15:0] des_event,
   output logic [15:0] fun_event,
   output logic pad_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // ============================================================
   // sources fire one registered cycle after the request
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         des_event <= 16'h0000;
         fun_event <= 16'h0000;
      end else begin
         des_event <= des_req;
         fun_event <= fun_req;
      end
   end
   // pad has a pull-up, so a released pad reads high
   assign pad_level = ext_reset_oe ? ext_reset_out : 1'b1;
endmodule

`default_nettype wire

// *** tb/rgs_sequencer_test.sv ***
`default_nettype none
`include "rgs_params.svh"

module rgs_sequencer_test
   import rgs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ============================================================
   // signals
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [15:0] des_req = 16'h0, fun_req = 16'h0, safe_cond = 16'h0;
   logic [15:0] des_event, fun_event;
   logic pll_in_use = 1'b0, lvd = 1'b0;
   logic hreadyout, hresp, ext_out, ext_oe, safe_req, exit_ok, irq, pad;
   rgs_seq_out_t seq_out;
   int err_total = 0;
   int tests_run = 0;

   always #2 hclk = ~hclk;

   rgs_sequencer #(.PH1_CYC(3), .PH2_CYC(2), .PH3_CYC(2)) i_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .des_event(des_event), .fun_event(fun_event),
      .safe_cond(safe_cond), .pll_in_use(pll_in_use),
      .low_voltage_detector_upper(lvd), .seq_out(seq_out),
      .ext_reset_out(ext_out), .ext_reset_oe(ext_oe),
      .safe_request(safe_req), .safe_exit_allow(exit_ok), .irq(irq));

   rgs_src_model i_src (.hclk(hclk), .hresetn(hresetn), .des_req(des_req),
      .fun_req(fun_req), .ext_reset_out(ext_out), .ext_reset_oe(ext_oe),
      .des_event(des_event), .fun_event(fun_event), .pad_level(pad));

   // ============================================================
   // common tasks
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (n >= 64) begin
         err_total++;
         give_verdict;
      end
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= `RGS_HTRANS_NONSEQ;
      hwrite <= wr;
      wait_rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy;
      q = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask

   // events reach the block one edge after the request and start it on the next
   task automatic fire(input logic [15:0] d, input logic [15:0] f);
      @(posedge hclk);
      des_req <= d;
      fun_req <= f;
      @(posedge hclk);
      des_req <= 16'h0;
      fun_req <= 16'h0;
      @(posedge hclk);
      #1;
   endtask

   task automatic wait_idle;
      int n;
      n = 0;
      while (seq_out.phase !== RGS_SEQ_IDLE && n < 400) begin
         @(posedge hclk);
         n++;
      end
      if (n >= 400) begin
         err_total++;
         give_verdict;
      end
   endtask

   // ============================================================
   // scenarios
   task automatic t_regs;
      for (int i = 0; i < 7; i++) rdc(8'(i * 4), 32'h0);
      rdc(`RGS_OFF_SEQ_STS, 32'h20);
      for (int i = 2; i < 5; i++) begin
         wr(8'(i * 4), 32'hFFFF1234);
         rdc(8'(i * 4), 32'h00001234);
         wr(8'(i * 4), 32'h0);
      end
      wr(`RGS_OFF_IRQ_MASK, 32'hFFFFFFFF);
      rdc(`RGS_OFF_IRQ_MASK, 32'h0000000F);
      wr(8'h24, 32'hFFFFFFFF);
      rdc(8'h24, 32'h0);
      wr(`RGS_OFF_IRQ_MASK, 32'h1);
      $display("t_regs done");
   endtask

   task automatic t_des;
      fire(16'h0004, 16'h0);
      chk(32'(seq_out.phase), 32'(RGS_SEQ_PH1));
      chk(32'(ext_oe), 32'h1);
      wait_idle;
      chk(32'(irq), 32'h1);
      wr(`RGS_OFF_DES, 32'h0);
      rdc(`RGS_OFF_DES, 32'h4);
      wr(`RGS_OFF_DES, 32'h4);
      rdc(`RGS_OFF_DES, 32'h4);
      rdc(`RGS_OFF_DES, 32'h0);
      wr(`RGS_OFF_IRQ_STS, 32'hF);
      @(negedge hclk);
      chk(32'(irq), 32'h0);
      $display("t_des done");
   endtask

   task automatic t_short;
      logic [15:0] fs[3] = '{16'h0002, 16'h0010, 16'h0000};
      logic [15:0] fb[3] = '{16'h0000, 16'h0010, 16'h0020};
      logic [15:0] src[3] = '{16'h0002, 16'h0010, 16'h0020};
      rgs_seq_state_t ph[3] = '{RGS_SEQ_PH3, RGS_SEQ_PH1, RGS_SEQ_PH1};
      logic [2:0] pl = 3'b011;
      // the middle case breaks the software rule on purpose
      for (int i = 0; i < 3; i++) begin
         wr(`RGS_OFF_FESS, 32'(fs[i]));
         wr(`RGS_OFF_FBRE, 32'(fb[i]));
         fire(16'h0, src[i]);
         chk(32'(seq_out.phase), 32'(ph[i]));
         chk(32'(pad), 32'(pl[i]));
         wait_idle;
         rdc(`RGS_OFF_FES, 32'(src[i]));
         wr(`RGS_OFF_FES, 32'(src[i]));
         repeat (4) @(posedge hclk);
      end
      wr(`RGS_OFF_FESS, 32'h0);
      wr(`RGS_OFF_FBRE, 32'h0);
      $display("t_short done");
   endtask

   task automatic t_abort;
      fire(16'h0, 16'h0001);
      wait_idle;
      fork
         wr(`RGS_OFF_FES, 32'h1);
         begin
            repeat (2) @(posedge hclk);
            des_req <= 16'h0001;
            @(posedge hclk);
            des_req <= 16'h0;
            // let the sequence start before waiting for idle
            repeat (2) @(posedge hclk);
         end
      join
      wait_idle;
      rdc(`RGS_OFF_FES, 32'h1);
      wr(`RGS_OFF_FES, 32'h1);
      rdc(`RGS_OFF_SEQ_STS, 32'h28);
      rdc(`RGS_OFF_SEQ_STS, 32'h20);
      rdc(`RGS_OFF_FES, 32'h0);
      wr(`RGS_OFF_DES, 32'h1);
      $display("t_abort done");
   endtask

   task automatic t_safe;
      wr(`RGS_OFF_SAFE_EN, 32'h40);
      safe_cond <= 16'h0040;
      repeat (3) @(posedge hclk);
      #1;
      chk(32'(safe_req), 32'h1);
      chk(32'(exit_ok), 32'h0);
      rdc(`RGS_OFF_FES, 32'h40);
      wr(`RGS_OFF_FES, 32'h40);
      repeat (4) @(posedge hclk);
      #1;
      chk(32'(exit_ok), 32'h1);
      safe_cond <= 16'h0;
      pll_in_use <= 1'b1;
      lvd <= 1'b1;
      @(posedge hclk);
      lvd <= 1'b0;
      rdc(`RGS_OFF_FES, 32'h8);
      pll_in_use <= 1'b0;
      $display("t_safe done");
   endtask

   // ============================================================
   // main sequence
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_des;
      t_short;
      t_abort;
      t_safe;
      give_verdict;
   end

   initial begin
      #400000;
      err_total++;
      give_verdict;
   end
endmodule

`default_nettype wire
